// ### hdl/cioc_cap_reg.sv
// one-bit register that loads on a take pulse, cleared at reset
`timescale 1ns/1ps
module cioc_cap_reg (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic take_i,
   input wire logic d_i,
   output logic q_o
);
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         q_o <= 1'b0;
      end else if (take_i) begin
         q_o <= d_i;
      end
   end
endmodule : cioc_cap_reg

// ### hdl/cioc_cfg.svh
// register map, field positions and reset values of the i/o logic cell
`ifndef CIOC_CFG_SVH
`define CIOC_CFG_SVH

`define CIOC_ADDR_W 4
`define CIOC_CTRL_OFS 4'h0
`define CIOC_STAT_OFS 4'h4
`define CIOC_CTRL_RST 32'h00000000

`define CIOC_MODE_LO 0
`define CIOC_MODE_HI 2
`define CIOC_IN_REG 3
`define CIOC_IN_FALL 4
`define CIOC_IN_DUAL 5
`define CIOC_OUT_REG 6
`define CIOC_OUT_FALL 7
`define CIOC_OUT_INV 8
`define CIOC_OUT_DUAL 9
`define CIOC_PULL_DN 10
`define CIOC_ROUTE_LO 11
`define CIOC_ROUTE_HI 12
`define CIOC_CFG_DONE 31
`define CIOC_CTRL_MASK 32'h80001FFF

`define CIOC_RESP_OKAY 2'h0
`define CIOC_RESP_SLVERR 2'h2

`endif

// ### hdl/cioc_edge_det.sv
// two-flop synchroniser with level and edge pulses
`timescale 1ns/1ps
module cioc_edge_det (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic async_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= async_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   assign level_o = s2;
   assign rise_o = s2 & ~s3;
   assign fall_o = ~s2 & s3;
endmodule : cioc_edge_det

// ### hdl/cioc_pkg.sv
// types shared by the i/o logic cell
package cioc_pkg;
   typedef enum logic [2:0] {
      CIOC_UNUSED,
      CIOC_INPUT,
      CIOC_OUTPUT,
      CIOC_BIDIR,
      CIOC_CLKOUT
   } cioc_mode_t;

   typedef enum logic [1:0] {
      CIOC_ROUTE_NONE,
      CIOC_ROUTE_GLOBAL_CLOCK_ROUTE,
      CIOC_ROUTE_GLOBAL_CONTROL_ROUTE,
      CIOC_ROUTE_SYNTH
   } cioc_route_t;
endpackage : cioc_pkg

// ### hdl/cioc_top.sv
// configurable i/o logic cell with axi4-lite configuration port
`timescale 1ns/1ps
`include "cioc_cfg.svh"

// What this block does
// - input mode enables only pad-to-core, passed straight or through the input register.
// - registered input is clocked by capture clock, rising or falling edge selectable.
// - bypass input route feeds another block directly and is never registered.
// - dual-edge input samples pad on both capture edges into two core streams.
// - output mode enables only core-to-pad; register uses launch clock, edge selectable.
// - an option inverts the output register value before it reaches the pad.
// - dual-edge output captures on both launch edges and muxes into one pad stream.
// - bidirectional mode enables input, output and output-enable paths together.
// - bidirectional input and output registering and edges are chosen independently.
// - clock output mode forwards the core clock tree signal to the pad.
// - output-enable register switches the pad driver when used as output.
// - with the driver disabled the pad is left undriven.
// - during configuration every pin is undriven with weak pull-up.
// - unused pins are undriven with pull-up, pull-down selectable instead.
// - bypass input can serve directly as synthesizer reference clock.
// - bypass input can drive the high-fanout global control route.
// - bypass data carries the pad only when input is unregistered; routes selectable.
module cioc_top
   import cioc_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   input wire logic [`CIOC_ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [`CIOC_ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic CAPTURE_CLOCK_I,
   input wire logic LAUNCH_CLOCK_I,
   input wire logic CORE_CLOCK_TREE_I,
   input wire logic CORE_OUT_I,
   input wire logic CORE_OE_I,
   output logic CORE_IN_O,
   output logic CORE_IN_FALL_O,
   output logic BYPASS_PATH_DATA_O,
   output logic GLOBAL_CLOCK_ROUTE_O,
   output logic GLOBAL_CONTROL_ROUTE_O,
   output logic SYNTH_CLOCK_ROUTE_O,
   input wire logic PAD_I,
   output logic PAD_O,
   output logic PAD_OE_O,
   output logic PULL_UP_O,
   output logic PULL_DN_O
);
   // configuration and bus state
   logic [31:0] ctrl;
   logic aw_held;
   logic w_held;
   logic [`CIOC_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic bvalid;
   logic [1:0] bresp;
   logic arready;
   logic awready;
   logic wready;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;

   // synchronised pins and clocks
   logic pad_s;
   logic cap_s;
   logic cap_rise;
   logic cap_fall;
   logic launch_s;
   logic launch_rise;
   logic launch_fall;
   logic fclk_s;

   // cell registers
   logic in_rise_q;
   logic in_fall_q;
   logic out_rise_q;
   logic out_fall_q;
   logic oe_rise_q;
   logic oe_fall_q;

   // pad-side and core-side output flops
   logic core_in;
   logic core_in_fall;
   logic bypass;
   logic route_global_clock_route;
   logic route_global_control_route;
   logic route_synth;
   logic pad_o;
   logic pad_oe;
   logic pull_up;
   logic pull_dn;

   cioc_edge_det u_pad_sync (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .async_i(PAD_I),
      .level_o(pad_s), .rise_o(), .fall_o());
   cioc_edge_det u_cap_sync (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .async_i(CAPTURE_CLOCK_I),
      .level_o(cap_s), .rise_o(cap_rise), .fall_o(cap_fall));
   cioc_edge_det u_launch_sync (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .async_i(LAUNCH_CLOCK_I),
      .level_o(launch_s), .rise_o(launch_rise), .fall_o(launch_fall));
   cioc_edge_det u_fclk_sync (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .async_i(CORE_CLOCK_TREE_I),
      .level_o(fclk_s), .rise_o(), .fall_o());

   // configuration fields
   wire cioc_mode_t mode = cioc_mode_t'(ctrl[`CIOC_MODE_HI:`CIOC_MODE_LO]);
   wire cioc_route_t route = cioc_route_t'(ctrl[`CIOC_ROUTE_HI:`CIOC_ROUTE_LO]);
   wire cfg_done = ctrl[`CIOC_CFG_DONE];
   wire in_reg_en = ctrl[`CIOC_IN_REG];
   wire in_edge_fall = ctrl[`CIOC_IN_FALL];
   wire in_dual = ctrl[`CIOC_IN_DUAL];
   wire out_reg_en = ctrl[`CIOC_OUT_REG];
   wire out_edge_fall = ctrl[`CIOC_OUT_FALL];
   wire out_invert = ctrl[`CIOC_OUT_INV];
   wire out_dual = ctrl[`CIOC_OUT_DUAL];
   wire pull_dn_sel = ctrl[`CIOC_PULL_DN];

   // path enables; undefined mode codes behave as an unused pin
   wire in_path_on = cfg_done & (mode == CIOC_INPUT | mode == CIOC_BIDIR);
   wire out_path_on = cfg_done & (mode == CIOC_OUTPUT | mode == CIOC_BIDIR);
   wire clk_on = cfg_done & (mode == CIOC_CLKOUT);
   wire pin_unused = cfg_done & ~in_path_on & ~out_path_on & ~clk_on;

   // both edges are always sampled; the edge option picks which one is used
   cioc_cap_reg u_in_rise (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .take_i(cap_rise), .d_i(pad_s), .q_o(in_rise_q));
   cioc_cap_reg u_in_fall (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .take_i(cap_fall), .d_i(pad_s), .q_o(in_fall_q));
   cioc_cap_reg u_out_rise (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .take_i(launch_rise), .d_i(CORE_OUT_I),
      .q_o(out_rise_q));
   cioc_cap_reg u_out_fall (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .take_i(launch_fall), .d_i(CORE_OUT_I),
      .q_o(out_fall_q));
   cioc_cap_reg u_oe_rise (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .take_i(launch_rise), .d_i(CORE_OE_I),
      .q_o(oe_rise_q));
   cioc_cap_reg u_oe_fall (
      .clk_i(MCLK_I), .rst_b_i(RST_B_I), .take_i(launch_fall), .d_i(CORE_OE_I),
      .q_o(oe_fall_q));

   // input side
   wire in_sel = in_edge_fall ? in_fall_q : in_rise_q;
   wire in_reg_val = in_dual ? in_rise_q : in_sel;
   wire next_core_in = in_path_on & (in_reg_en ? in_reg_val : pad_s);
   wire next_core_in_fall = in_path_on & in_reg_en & in_dual & in_fall_q;
   // bypass never passes the capture register, only the pin synchroniser
   wire next_bypass = in_path_on & ~in_reg_en & pad_s;
   wire next_route_global_clock_route = next_bypass & (route == CIOC_ROUTE_GLOBAL_CLOCK_ROUTE);
   wire next_route_global_control_route = next_bypass & (route == CIOC_ROUTE_GLOBAL_CONTROL_ROUTE);
   wire next_route_synth = next_bypass & (route == CIOC_ROUTE_SYNTH);

   // output side
   wire out_sel = out_edge_fall ? out_fall_q : out_rise_q;
   wire out_dual_val = launch_s ? out_rise_q : out_fall_q;
   wire out_reg_val = (out_dual ? out_dual_val : out_sel) ^ out_invert;
   wire out_val = out_reg_en ? out_reg_val : CORE_OUT_I;
   wire oe_sel = out_edge_fall ? oe_fall_q : oe_rise_q;
   wire oe_val = out_reg_en ? oe_sel : CORE_OE_I;
   wire next_pad_oe = clk_on | (out_path_on & oe_val);
   wire next_pad_o = next_pad_oe & (clk_on ? fclk_s : out_val);
   wire next_pull_up = ~cfg_done | (pin_unused & ~pull_dn_sel);
   wire next_pull_dn = pin_unused & pull_dn_sel;

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         core_in <= 1'b0;
         core_in_fall <= 1'b0;
         bypass <= 1'b0;
         route_global_clock_route <= 1'b0;
         route_global_control_route <= 1'b0;
         route_synth <= 1'b0;
         pad_o <= 1'b0;
         pad_oe <= 1'b0;
         pull_up <= 1'b1;
         pull_dn <= 1'b0;
      end else begin
         core_in <= next_core_in;
         core_in_fall <= next_core_in_fall;
         bypass <= next_bypass;
         route_global_clock_route <= next_route_global_clock_route;
         route_global_control_route <= next_route_global_control_route;
         route_synth <= next_route_synth;
         pad_o <= next_pad_o;
         pad_oe <= next_pad_oe;
         pull_up <= next_pull_up;
         pull_dn <= next_pull_dn;
      end
   end

   // axi4-lite slave: address and data taken in either order, held until both
   wire aw_take = S_AXI_AWVALID_I & awready;
   wire w_take = S_AXI_WVALID_I & wready;
   wire have_aw = aw_held | aw_take;
   wire have_w = w_held | w_take;
   wire [`CIOC_ADDR_W-1:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR_I;
   wire [31:0] wr_data = w_held ? w_data : S_AXI_WDATA_I;
   wire [3:0] wr_strb = w_held ? w_strb : S_AXI_WSTRB_I;
   wire wr_fire = have_aw & have_w & ~bvalid;
   wire wr_ctrl = wr_fire & (wr_addr == `CIOC_CTRL_OFS);
   wire wr_ok = wr_addr == `CIOC_CTRL_OFS | wr_addr == `CIOC_STAT_OFS;
   wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire [31:0] next_ctrl = ((ctrl & ~strb_mask) | (wr_data & strb_mask)) & `CIOC_CTRL_MASK;
   wire b_done = bvalid & S_AXI_BREADY_I;
   wire next_awready = ~bvalid & ~have_aw | b_done;
   wire next_wready = ~bvalid & ~have_w | b_done;

   wire ar_take = S_AXI_ARVALID_I & arready;
   wire r_done = rvalid & S_AXI_RREADY_I;
   wire [31:0] stat_word = {22'h000000, pull_dn, pull_up, pad_oe, pad_o, oe_sel, out_sel,
                            in_fall_q, in_rise_q, launch_s, cap_s};
   wire rd_ctrl = S_AXI_ARADDR_I == `CIOC_CTRL_OFS;
   wire rd_stat = S_AXI_ARADDR_I == `CIOC_STAT_OFS;
   wire [31:0] next_rdata = rd_ctrl ? ctrl : (rd_stat ? stat_word : 32'h00000000);
   wire [1:0] next_rresp = (rd_ctrl | rd_stat) ? `CIOC_RESP_OKAY : `CIOC_RESP_SLVERR;

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         ctrl <= `CIOC_CTRL_RST;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= 2'h0;
      end else begin
         awready <= next_awready;
         wready <= next_wready;
         if (aw_take) begin
            aw_addr <= S_AXI_AWADDR_I;
         end
         if (w_take) begin
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
         end
         aw_held <= have_aw & ~wr_fire;
         w_held <= have_w & ~wr_fire;
         if (wr_ctrl) begin
            ctrl <= next_ctrl;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? `CIOC_RESP_OKAY : `CIOC_RESP_SLVERR;
         end else if (b_done) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= 2'h0;
      end else if (ar_take) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end else if (r_done) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
      end
   end

   assign S_AXI_AWREADY_O = awready;
   assign S_AXI_WREADY_O = wready;
   assign S_AXI_BVALID_O = bvalid;
   assign S_AXI_BRESP_O = bresp;
   assign S_AXI_ARREADY_O = arready;
   assign S_AXI_RVALID_O = rvalid;
   assign S_AXI_RDATA_O = rdata;
   assign S_AXI_RRESP_O = rresp;
   assign CORE_IN_O = core_in;
   assign CORE_IN_FALL_O = core_in_fall;
   assign BYPASS_PATH_DATA_O = bypass;
   assign GLOBAL_CLOCK_ROUTE_O = route_global_clock_route;
   assign GLOBAL_CONTROL_ROUTE_O = route_global_control_route;
   assign SYNTH_CLOCK_ROUTE_O = route_synth;
   assign PAD_O = pad_o;
   assign PAD_OE_O = pad_oe;
   assign PULL_UP_O = pull_up;
   assign PULL_DN_O = pull_dn;

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_B_I);

   a_cfg_hiz_pullup: assert property (!cfg_done |=> !PAD_OE_O && PULL_UP_O && !PULL_DN_O)
      else $error("pin driven or not pulled up during configuration");
   a_off_no_drive: assert property (!PAD_OE_O |-> !PAD_O)
      else $error("pad value present while driver disabled");
   a_unused_pull: assert property (pin_unused |=> !PAD_OE_O && PULL_DN_O == $past(pull_dn_sel)
                                   && PULL_UP_O == !$past(pull_dn_sel))
      else $error("unused pin pull selection wrong");
   a_bypass_reg_off: assert property (in_reg_en |=> !BYPASS_PATH_DATA_O)
      else $error("bypass active while input is registered");
   a_bypass_direct: assert property (in_path_on && !in_reg_en |=> BYPASS_PATH_DATA_O == $past(pad_s))
      else $error("bypass does not follow synchronised pad");
   a_synth_route: assert property (route == CIOC_ROUTE_SYNTH && !in_reg_en && in_path_on
                                   |=> SYNTH_CLOCK_ROUTE_O == BYPASS_PATH_DATA_O)
      else $error("synth route does not carry bypass data");
   a_in_dual_streams: assert property (in_path_on && in_reg_en && in_dual && cap_fall
                                       ##1 $stable(ctrl) |=> CORE_IN_FALL_O == $past(pad_s, 2))
      else $error("falling-edge input stream wrong");
   a_in_edge_rise: assert property (in_path_on && in_reg_en && !in_dual && !in_edge_fall && cap_rise
                                    ##1 $stable(ctrl) && !cap_rise |=> CORE_IN_O == $past(pad_s, 2))
      else $error("rising-edge input capture wrong");
   a_out_launch: assert property (launch_rise |=> out_rise_q == $past(CORE_OUT_I))
      else $error("output register missed launch edge");
   a_out_invert: assert property (out_path_on && out_reg_en && !out_dual && out_invert && next_pad_oe
                                  |=> PAD_O == !$past(out_sel))
      else $error("inverted output wrong");
   a_out_dual_mux: assert property (out_path_on && out_reg_en && out_dual && next_pad_oe && launch_s
                                    |=> PAD_O == ($past(out_rise_q) ^ $past(out_invert)))
      else $error("dual-edge output mux wrong");
   a_oe_follow: assert property (out_path_on && !out_reg_en |=> PAD_OE_O == $past(CORE_OE_I))
      else $error("pad enable does not follow core enable");
   a_clk_forward: assert property (clk_on |=> PAD_OE_O && PAD_O == $past(fclk_s))
      else $error("clock output not forwarded");
   a_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
      else $error("write response dropped");

   c_dual_input: cover property (in_path_on && in_reg_en && in_dual && cap_fall ##2 CORE_IN_FALL_O);
   c_clock_out: cover property (clk_on ##1 PAD_O ##1 !PAD_O);
   c_bidir_drive: cover property (mode == CIOC_BIDIR && cfg_done ##1 PAD_OE_O);
   c_axi_write: cover property (wr_ctrl ##1 S_AXI_BVALID_O && S_AXI_BREADY_I);
endmodule : cioc_top

// ### sim/cioc_pad_model.sv
// pad-side model: outside driver, weak pulls and a floating pad
`timescale 1ns/1ps
module cioc_pad_model (
   input wire logic clk_i,
   input wire logic pad_o_i,
   input wire logic pad_oe_i,
   input wire logic pull_up_i,
   input wire logic pull_dn_i,
   input wire logic ext_en_i,
   input wire logic ext_val_i,
   output logic pad_i_o
);
   logic drift = 1'b0;
   // an undriven pad without pull must never read as a steady level
   always @(posedge clk_i) begin
      drift <= ~drift;
   end
   assign pad_i_o = pad_oe_i ? pad_o_i : ext_en_i ? ext_val_i :
      pull_up_i ? 1'b1 : pull_dn_i ? 1'b0 : drift;
endmodule : cioc_pad_model

// ### sim/cioc_top_tb.sv
// self-checking bench for the i/o logic cell
`timescale 1ns/1ps
`include "cioc_cfg.svh"
module cioc_top_tb;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic capture = 1'b0, launch = 1'b0, ctree = 1'b0, core_out = 1'b0, core_oe = 1'b0;
   logic ext_en = 1'b0, ext_val = 1'b0;
   logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, pad_in, pad_o, pad_oe, pull_up, pull_dn;
   logic core_in, core_in_fall, bypass, global_clock_route_r, global_control_route_r, synth_r;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [1:0] resp;
   logic [31:0] rd;
   int fail_count = 0;
   int check_count = 0;

   always #10 mclk = ~mclk;

   cioc_top cioc_top_i (.MCLK_I(mclk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(w_rdy),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(ar_rdy),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .CAPTURE_CLOCK_I(capture), .LAUNCH_CLOCK_I(launch),
      .CORE_CLOCK_TREE_I(ctree), .CORE_OUT_I(core_out), .CORE_OE_I(core_oe),
      .CORE_IN_O(core_in), .CORE_IN_FALL_O(core_in_fall), .BYPASS_PATH_DATA_O(bypass),
      .GLOBAL_CLOCK_ROUTE_O(global_clock_route_r), .GLOBAL_CONTROL_ROUTE_O(global_control_route_r),
      .SYNTH_CLOCK_ROUTE_O(synth_r), .PAD_I(pad_in), .PAD_O(pad_o), .PAD_OE_O(pad_oe),
      .PULL_UP_O(pull_up), .PULL_DN_O(pull_dn));

   cioc_pad_model cioc_pad_model_i (.clk_i(mclk), .pad_o_i(pad_o), .pad_oe_i(pad_oe),
      .pull_up_i(pull_up), .pull_dn_i(pull_dn), .ext_en_i(ext_en), .ext_val_i(ext_val),
      .pad_i_o(pad_in));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // pin paths pass a 2ff synchroniser plus registers, so six cycles covers them
   task automatic settle;
      repeat (6) @(posedge mclk);
   endtask : settle

   task automatic axi_wr(input logic [3:0] addr, input logic [31:0] data);
      int n;
      @(posedge mclk);
      awaddr <= addr;
      wdata <= data;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (awvalid && aw_rdy) awvalid <= 1'b0;
         if (wvalid && w_rdy) wvalid <= 1'b0;
         if (bvalid && bready) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 50) begin
         chk(32'h0, 32'h1);
         tally_and_finish();
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] addr);
      int n;
      @(posedge mclk);
      araddr <= addr;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (arvalid && ar_rdy) arvalid <= 1'b0;
         if (rvalid && rready) begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 50) begin
         chk(32'h0, 32'h1);
         tally_and_finish();
      end
   endtask : axi_rd

   task automatic cfg(input logic [31:0] data);
      axi_wr(`CIOC_CTRL_OFS, data);
      chk(resp, `CIOC_RESP_OKAY);
      settle();
   endtask : cfg

   task automatic t_reset;
      chk({pull_up, pull_dn, pad_oe, pad_o}, 32'h8);
      axi_rd(`CIOC_CTRL_OFS);
      chk(rd, `CIOC_CTRL_RST);
      axi_rd(`CIOC_STAT_OFS);
      chk(rd, 32'h00000100);
      chk(resp, `CIOC_RESP_OKAY);
      axi_rd(4'h8);
      chk(rd, 32'h00000000);
      chk(resp, `CIOC_RESP_SLVERR);
      axi_wr(4'hC, 32'hFFFFFFFF);
      chk(resp, `CIOC_RESP_SLVERR);
      $display("test reset done");
   endtask : t_reset

   task automatic t_config;
      @(posedge mclk);
      core_out <= 1'b1;
      core_oe <= 1'b1;
      cfg(32'h00000002);
      chk({pad_oe, pull_up, pull_dn}, 32'h2);
      $display("test config done");
   endtask : t_config

   task automatic t_out_plain;
      cfg(32'h80000002);
      chk({pad_oe, pad_o, core_in}, 32'h6);
      @(posedge mclk);
      core_oe <= 1'b0;
      settle();
      chk({pad_oe, pad_o}, 32'h0);
      $display("test output plain done");
   endtask : t_out_plain

   task automatic t_out_reg;
      @(posedge mclk);
      core_oe <= 1'b1;
      cfg(32'h80000142);
      @(posedge mclk);
      launch <= 1'b1;
      settle();
      chk({pad_oe, pad_o}, 32'h2);
      @(posedge mclk);
      core_out <= 1'b0;
      settle();
      chk(pad_o, 32'h0);
      @(posedge mclk);
      launch <= 1'b0;
      settle();
      chk(pad_o, 32'h0);
      @(posedge mclk);
      launch <= 1'b1;
      settle();
      chk(pad_o, 32'h1);
      $display("test output registered done");
   endtask : t_out_reg

   // fall register leads while launch is low, rise register while high
   task automatic t_out_dual;
      cfg(32'h80000242);
      @(posedge mclk);
      core_out <= 1'b1;
      launch <= 1'b0;
      settle();
      chk({pad_oe, pad_o}, 32'h3);
      @(posedge mclk);
      core_out <= 1'b0;
      launch <= 1'b1;
      settle();
      chk({pad_oe, pad_o}, 32'h2);
      $display("test output dual done");
   endtask : t_out_dual

   task automatic t_in_plain;
      logic [1:0] r;
      @(posedge mclk);
      ext_en <= 1'b1;
      ext_val <= 1'b1;
      for (int i = 1; i < 4; i++) begin
         r = i[1:0];
         cfg(32'h80000001 | (32'(r) << 11));
         chk({pad_oe, core_in, bypass}, 32'h3);
         chk({global_clock_route_r, global_control_route_r, synth_r}, {r == 2'h1, r == 2'h2, r == 2'h3});
      end
      $display("test input plain done");
   endtask : t_in_plain

   task automatic cap(input logic c, input logic p);
      @(posedge mclk);
      ext_val <= p;
      settle();
      @(posedge mclk);
      capture <= c;
      settle();
   endtask : cap

   task automatic t_in_reg;
      cfg(32'h80000019);
      cap(1'b1, 1'b0);
      cap(1'b0, 1'b0);
      chk({core_in, bypass}, 32'h0);
      cap(1'b1, 1'b1);
      chk(core_in, 32'h0);
      cap(1'b0, 1'b1);
      chk(core_in, 32'h1);
      $display("test input registered done");
   endtask : t_in_reg

   task automatic t_in_dual;
      cfg(32'h80000029);
      cap(1'b1, 1'b1);
      cap(1'b0, 1'b0);
      chk({core_in, core_in_fall}, 32'h2);
      cap(1'b1, 1'b0);
      cap(1'b0, 1'b1);
      chk({core_in, core_in_fall}, 32'h1);
      $display("test input dual done");
   endtask : t_in_dual

   task automatic t_bidir;
      @(posedge mclk);
      ext_en <= 1'b0;
      core_out <= 1'b1;
      core_oe <= 1'b1;
      cfg(32'h80000003);
      chk({pad_oe, pad_o, core_in}, 32'h7);
      @(posedge mclk);
      core_oe <= 1'b0;
      ext_en <= 1'b1;
      ext_val <= 1'b0;
      settle();
      chk({pad_oe, core_in}, 32'h0);
      // input registered on rising capture, output and oe on falling launch
      cfg(32'h800000CB);
      @(posedge mclk);
      launch <= 1'b0;
      settle();
      cap(1'b1, 1'b1);
      chk({pad_oe, core_in}, 32'h1);
      @(posedge mclk);
      core_oe <= 1'b1;
      ext_val <= 1'b0;
      launch <= 1'b1;
      settle();
      chk({pad_oe, core_in}, 32'h1);
      @(posedge mclk);
      launch <= 1'b0;
      settle();
      chk({pad_oe, pad_o, core_in}, 32'h7);
      $display("test bidir done");
   endtask : t_bidir

   task automatic t_clk_unused;
      cfg(32'h80000004);
      @(posedge mclk);
      ctree <= 1'b1;
      settle();
      chk({pad_oe, pad_o}, 32'h3);
      @(posedge mclk);
      ctree <= 1'b0;
      settle();
      chk(pad_o, 32'h0);
      cfg(32'h80000400);
      chk({pad_oe, pull_up, pull_dn}, 32'h1);
      cfg(32'h80000000);
      chk({pad_oe, pull_up, pull_dn}, 32'h2);
      $display("test clock out and unused done");
   endtask : t_clk_unused

   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_config();
      t_out_plain();
      t_out_reg();
      t_out_dual();
      t_in_plain();
      t_in_reg();
      t_in_dual();
      t_bidir();
      t_clk_unused();
      tally_and_finish();
   end
endmodule : cioc_top_tb
